// File: logic/gsc_byte_mem.sv
// Small report buffer with one write port and a registered read port
`timescale 1ns/1ns
module gsc_byte_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_we,
    input  wire logic [AW-1:0]    i_waddr,
    input  wire logic [WIDTH-1:0] i_wdata,
    input  wire logic [AW-1:0]    i_raddr,
    output logic      [WIDTH-1:0] o_rdata
);
    logic [WIDTH-1:0] mem_reg [0:DEPTH-1];

    // ==========================================================
    // Storage write
    always_ff @(posedge i_clk)
    begin
        if (i_we)
            mem_reg[i_waddr] <= i_wdata;
    end

    // ==========================================================
    // Registered read, one cycle latency
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            o_rdata <= '0;
        else
            o_rdata <= mem_reg[i_raddr];
    end
endmodule

// File: logic/gsc_clk_out.sv
// Output clock generator with selectable divider and duty cycle
`timescale 1ns/1ns
module gsc_clk_out (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic [2:0] i_div,
    input  wire logic [1:0] i_duty,
    output logic            o_clk_out
);
    logic [9:0] cnt_reg;
    logic [9:0] cnt_next;
    wire  [9:0] period_m1;
    wire  [9:0] high_len;

    // ==========================================================
    // Period is four cycles shifted by the divider code, high time quarters of it
    assign period_m1 = (10'h004 << i_div) - 10'h001;
    assign high_len  = {8'h00, i_duty} << i_div;
    assign cnt_next  = (cnt_reg >= period_m1) ? 10'h000 : cnt_reg + 10'h001;

    // Counter and output level; code 00 keeps output low
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            cnt_reg   <= 10'h000;
            o_clk_out <= 1'b0;
        end
        else
        begin
            cnt_reg   <= cnt_next;
            o_clk_out <= (cnt_next < high_len);
        end
    end
endmodule

// File: logic/gsc_cmd_top.sv
// Command interpreter for pin read-back and run-time settings reports
`timescale 1ns/1ns
`include "gsc_map.svh"

// Function
// - Code 0x51 requests pin read-back; all other report bytes are ignored.
// - Reply bytes 2,4,6,8 hold pin level 0/1, or 0xEE when not general use.
// - Reply bytes 3,5,7,9 hold direction, 0 out 1 in, or 0xEF otherwise.
// - Code 0x60 changes run-time settings; byte 1 is ignored.
// - Settings live in working storage only; reset restores power-up defaults.
// - Byte 2 bit 7 set loads bits 4-0 as clock-output configuration.
// - Byte 2 bits 4-3 pick duty 0, 25, 50 or 75 percent.
// - Byte 2 bits 2-0 pick the output clock divider; bits 6-5 ignored.
// - Byte 3 bit 7 set loads bits 2-0 as DAC reference selection.
// - Byte 3 bits 2-1 set reference module level: off, 1.024, 2.048, 4.096V.
// - Byte 3 bit 0 picks reference module (1) or supply rail (0).
// - Byte 4 bit 7 set loads bits 4-0 as DAC code; bits 6-5 ignored.
module gsc_cmd_top (
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_n,
    input  wire logic [9:0]             i_address,
    input  wire logic                   i_read,
    input  wire logic                   i_write,
    input  wire logic [31:0]            i_writedata,
    output logic      [31:0]            o_readdata,
    output logic                        o_waitrequest,
    input  wire gsc_pkg::gsc_pins_s     i_pins,
    output gsc_pkg::gsc_settings_s      o_settings,
    output logic                        o_clk_out
);
    import gsc_pkg::*;

    gsc_state_e     state_reg;
    gsc_state_e     state_next;
    gsc_settings_s  set_reg;
    logic [2:0]     fetch_idx_reg;
    logic [3:0]     reply_idx_reg;
    logic [7:0]     cmd_reg [0:4];
    logic [1:0]     rd_stage_reg;
    logic [31:0]    readdata_reg;
    logic           done_reg;
    logic [7:0]     cmd_rdata;
    logic [7:0]     reply_rdata;

    // ==========================================================
    // Reply byte builder
    function automatic logic [7:0] reply_byte(input logic [3:0] idx, input logic [7:0] code,
                                              input gsc_pins_s pins);
        logic [1:0] pin;
        logic [7:0] val;
        pin = 2'(idx - 4'h2 >> 1);
        val = 8'h00;
        if (idx == 4'h0)
            val = code;
        else if (idx == 4'h1)
            val = (code == `GSC_CODE_GET_PINS || code == `GSC_CODE_SET_RUN) ?
                  `GSC_STATUS_OK : `GSC_STATUS_BAD_CMD;
        else if (code == `GSC_CODE_GET_PINS && !idx[0])
            val = pins.gpio_mode[pin] ? {7'h00, pins.level[pin]} : `GSC_LEVEL_NOT_GPIO;
        else if (code == `GSC_CODE_GET_PINS)
            val = pins.gpio_mode[pin] ? {7'h00, pins.dir_in[pin]} : `GSC_DIR_NOT_GPIO;
        return val;
    endfunction

    // ==========================================================
    // Bus decode
    wire [1:0] bus_region  = i_address[9:8];
    wire [5:0] bus_index   = i_address[7:2];
    wire [1:0] csr_index   = i_address[3:2];
    wire       busy        = (state_reg != GSC_IDLE);
    wire       wr_fire     = i_write && !busy;
    wire       rd_fire     = i_read && !busy && (rd_stage_reg == 2'h2);
    wire       cmd_we      = wr_fire && (bus_region == `GSC_REGION_CMD);
    wire       start       = wr_fire && (bus_region == `GSC_REGION_CSR) &&
                             (csr_index == `GSC_CSR_CTRL) && i_writedata[`GSC_CTRL_START_BIT];
    wire [5:0] cmd_raddr   = busy ? {3'h0, fetch_idx_reg} : bus_index;
    wire       reply_we    = (state_reg == GSC_REPLY);
    wire [7:0] reply_wdata = reply_byte(reply_idx_reg, cmd_reg[0], i_pins);

    // Waitrequest while busy, and for two cycles of every read
    assign o_waitrequest = busy || (i_read && rd_stage_reg != 2'h2);
    assign o_readdata    = readdata_reg;

    // ==========================================================
    // Register read mux
    wire [31:0] status_word = {16'h0000, cmd_reg[0], 6'h00, done_reg, busy};
    wire [31:0] set_word    = {11'h000, set_reg.dac_code, 5'h00, set_reg.ref_level,
                               set_reg.ref_internal, 3'h0, set_reg.clk_duty, set_reg.clk_div};
    wire [31:0] csr_word    = (csr_index == `GSC_CSR_STATUS)   ? status_word :
                              (csr_index == `GSC_CSR_SETTINGS) ? set_word : 32'h0000_0000;
    wire [31:0] rd_mux      = (bus_region == `GSC_REGION_CMD)   ? {24'h000000, cmd_rdata} :
                              (bus_region == `GSC_REGION_REPLY) ? {24'h000000, reply_rdata} :
                              (bus_region == `GSC_REGION_CSR)   ? csr_word : 32'h0000_0000;

    // ==========================================================
    // Report buffers
    gsc_byte_mem #(.WIDTH(8), .DEPTH(64), .AW(6)) u_cmd_mem (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_we    (cmd_we),
        .i_waddr (bus_index),
        .i_wdata (i_writedata[7:0]),
        .i_raddr (cmd_raddr),
        .o_rdata (cmd_rdata)
    );

    gsc_byte_mem #(.WIDTH(8), .DEPTH(64), .AW(6)) u_reply_mem (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_we    (reply_we),
        .i_waddr ({2'h0, reply_idx_reg}),
        .i_wdata (reply_wdata),
        .i_raddr (bus_index),
        .o_rdata (reply_rdata)
    );

    // ==========================================================
    // Read staging: issue, capture, answer
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            rd_stage_reg <= 2'h0;
            readdata_reg <= 32'h0000_0000;
        end
        else if (rd_fire)
            rd_stage_reg <= 2'h0;
        else if (i_read && !busy)
        begin
            rd_stage_reg <= rd_stage_reg + 2'h1;
            if (rd_stage_reg == 2'h1)
                readdata_reg <= rd_mux;
        end
    end

    // ==========================================================
    // Controller next state
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            GSC_IDLE:
                if (start)
                    state_next = GSC_FETCH;
            GSC_FETCH:
                if (fetch_idx_reg == `GSC_FETCH_LAST)
                    state_next = GSC_EXEC;
            GSC_EXEC:
                state_next = GSC_REPLY;
            GSC_REPLY:
                if (reply_idx_reg == `GSC_REPLY_LAST)
                    state_next = GSC_IDLE;
        endcase
    end

    // Controller registers and counters
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            state_reg     <= GSC_IDLE;
            fetch_idx_reg <= 3'h0;
            reply_idx_reg <= 4'h0;
            done_reg      <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            fetch_idx_reg <= (state_reg == GSC_FETCH) ? fetch_idx_reg + 3'h1 : 3'h0;
            reply_idx_reg <= (state_reg == GSC_REPLY) ? reply_idx_reg + 4'h1 : 4'h0;
            if (start)
                done_reg <= 1'b0;
            else if (state_reg == GSC_REPLY && reply_idx_reg == `GSC_REPLY_LAST)
                done_reg <= 1'b1;
        end
    end

    // ==========================================================
    // Capture bytes 0 to 4; byte k arrives one cycle after its fetch
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            for (int k = 0; k < 5; k++)
                cmd_reg[k] <= 8'h00;
        end
        else if (state_reg == GSC_FETCH && fetch_idx_reg != 3'h0)
            cmd_reg[fetch_idx_reg - 3'h1] <= cmd_rdata;
    end

    // ==========================================================
    // Working settings, restored to defaults by reset only
    wire exec_set = (state_reg == GSC_EXEC) && (cmd_reg[0] == `GSC_CODE_SET_RUN);

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            set_reg.clk_duty     <= `GSC_DEF_DUTY;
            set_reg.clk_div      <= `GSC_DEF_DIV;
            set_reg.ref_level    <= `GSC_DEF_REF_LVL;
            set_reg.ref_internal <= `GSC_DEF_REF_SRC;
            set_reg.dac_code     <= `GSC_DEF_DAC;
        end
        else if (exec_set)
        begin
            if (cmd_reg[2][`GSC_LOAD_BIT])
            begin
                set_reg.clk_duty <= cmd_reg[2][`GSC_DUTY_HI:`GSC_DUTY_LO];
                set_reg.clk_div  <= cmd_reg[2][`GSC_DIV_HI:0];
            end
            if (cmd_reg[3][`GSC_LOAD_BIT])
            begin
                set_reg.ref_level    <= cmd_reg[3][`GSC_REF_LVL_HI:`GSC_REF_LVL_LO];
                set_reg.ref_internal <= cmd_reg[3][`GSC_REF_SRC_BIT];
            end
            if (cmd_reg[4][`GSC_LOAD_BIT])
                set_reg.dac_code <= cmd_reg[4][`GSC_DAC_HI:0];
        end
    end

    assign o_settings = set_reg;

    // ==========================================================
    // Output clock from the working divider and duty
    gsc_clk_out u_clk_out (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_div     (set_reg.clk_div),
        .i_duty    (set_reg.clk_duty),
        .o_clk_out (o_clk_out)
    );
endmodule

// File: pkg/gsc_map.svh
// Offsets, field positions, command codes and reset defaults of the command block
`ifndef GSC_MAP_SVH
`define GSC_MAP_SVH

// ==========================================================
// Bus address regions (byte addresses, one word per entry)
`define GSC_REGION_CMD      2'h0
`define GSC_REGION_REPLY    2'h1
`define GSC_REGION_CSR      2'h2
`define GSC_CSR_CTRL        2'h0
`define GSC_CSR_STATUS      2'h1
`define GSC_CSR_SETTINGS    2'h2
`define GSC_CTRL_START_BIT  0

// ==========================================================
// Command codes and reply values
`define GSC_CODE_GET_PINS   8'h51
`define GSC_CODE_SET_RUN    8'h60
`define GSC_STATUS_OK       8'h00
`define GSC_STATUS_BAD_CMD  8'h01
`define GSC_LEVEL_NOT_GPIO  8'hEE
`define GSC_DIR_NOT_GPIO    8'hEF
`define GSC_REPLY_LAST      4'h9
`define GSC_FETCH_LAST      3'h5

// ==========================================================
// Settings byte fields
`define GSC_LOAD_BIT        7
`define GSC_DUTY_HI         4
`define GSC_DUTY_LO         3
`define GSC_DIV_HI          2
`define GSC_REF_LVL_HI      2
`define GSC_REF_LVL_LO      1
`define GSC_REF_SRC_BIT     0
`define GSC_DAC_HI          4

// ==========================================================
// Power-up defaults of the working settings
`define GSC_DEF_DUTY        2'h2
`define GSC_DEF_DIV         3'h0
`define GSC_DEF_REF_LVL     2'h0
`define GSC_DEF_REF_SRC     1'h0
`define GSC_DEF_DAC         5'h00

`endif

// File: pkg/gsc_pkg.sv
// Types shared by the command block
package gsc_pkg;

    // Controller states
    typedef enum logic [1:0] {GSC_IDLE, GSC_FETCH, GSC_EXEC, GSC_REPLY} gsc_state_e;

    // Working run-time settings
    typedef struct packed {
        logic [1:0] clk_duty;
        logic [2:0] clk_div;
        logic [1:0] ref_level;
        logic       ref_internal;
        logic [4:0] dac_code;
    } gsc_settings_s;

    // Sampled state of the four general pins
    typedef struct packed {
        logic [3:0] gpio_mode;
        logic [3:0] level;
        logic [3:0] dir_in;
    } gsc_pins_s;

endpackage

// File: verif/gsc_cmd_assertions.sv
// Checker of bus timing, working settings and output clock of the command block
`timescale 1ns/1ns
`include "gsc_map.svh"
module gsc_cmd_checker (
    input wire logic                  i_clk,
    input wire logic                  i_rst_n,
    input wire logic                  i_read,
    input wire logic [31:0]           o_readdata,
    input wire logic                  o_waitrequest,
    input wire gsc_pkg::gsc_settings_s o_settings,
    input wire logic                  o_clk_out
);
    import gsc_pkg::*;
    logic [9:0] stab_cnt;
    // ==========================================================
    // Cycles with unchanged settings, saturating
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n || !$stable(o_settings))
            stab_cnt <= 10'h000;
        else if (stab_cnt != 10'h3FF)
            stab_cnt <= stab_cnt + 10'h001;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // ==========================================================
    // Properties
    reset_defaults_a: assert property (disable iff (1'b0) !i_rst_n |=> o_settings ==
        {`GSC_DEF_DUTY, `GSC_DEF_DIV, `GSC_DEF_REF_LVL, `GSC_DEF_REF_SRC, `GSC_DEF_DAC} && o_readdata == 32'h0)
        else $error("settings not at defaults after reset");
    settings_by_cmd_a: assert property ($changed(o_settings) && $past(i_rst_n) |-> $past(o_waitrequest))
        else $error("settings changed outside a command");
    clk_off_a: assert property (stab_cnt == 10'h3FF && o_settings.clk_duty == 2'h0 |-> !o_clk_out)
        else $error("output clock high at zero duty");
    clk_runs_a: assert property (stab_cnt == 10'h3FF && o_settings.clk_duty != 2'h0 |-> ##[0:512] $rose(o_clk_out))
        else $error("output clock not toggling");
    clk_half_a: assert property (stab_cnt > 10'h040 && o_settings[12:8] == 5'h10 && $rose(o_clk_out)
        |-> o_clk_out ##1 o_clk_out ##1 (!o_clk_out)[*2] ##1 o_clk_out) else $error("half duty shape wrong");
    read_wait_a: assert property ($rose(i_read) |-> o_waitrequest[*2]) else $error("read answered too soon");
    read_done_a: assert property (i_read && o_waitrequest |-> ##[1:24] !o_waitrequest) else $error("read hangs");
    rdata_hold_a: assert property ($changed(o_readdata) && $past(i_rst_n) |-> $past(i_read))
        else $error("read data changed without a read");
    cover property ($changed(o_settings) && $past(i_rst_n));
    cover property (i_read && !o_waitrequest);
    cover property ($rose(o_clk_out));
endmodule
bind gsc_cmd_top gsc_cmd_checker i_gsc_cmd_checker (.i_clk, .i_rst_n, .i_read, .o_readdata, .o_waitrequest,
    .o_settings, .o_clk_out);

// File: verif/gsc_cmd_top_bench.sv
// Self-checking bench of the command block
`timescale 1ns/1ns
`include "gsc_map.svh"
module gsc_cmd_top_bench;
    import gsc_pkg::*;
    logic          i_clk, i_rst_n, i_read, i_write, pin_sel, o_waitrequest, o_clk_out;
    logic [9:0]    i_address;
    logic [31:0]   i_writedata, o_readdata, rd;
    gsc_pins_s     pins;
    gsc_settings_s o_settings, exp_set;
    int            err_count, compares, cyc;
    gsc_cmd_top i_gsc_cmd_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .i_pins(pins), .o_settings(o_settings), .o_clk_out(o_clk_out));
    gsc_pin_model i_gsc_pin_model (.i_sel(pin_sel), .o_pins(pins));
    // Clock and hang guard
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            err_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // ==========================================================
    // Bus cycles: request held until waitrequest is seen low
    task automatic bus_op(input logic wr, input logic [9:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_address <= a;
        i_writedata <= d;
        i_write <= wr;
        i_read <= ~wr;
        // Waitrequest and read data taken at the rising edge that ends the transfer
        do
        begin
            @(posedge i_clk);
        end while (o_waitrequest !== 1'b0);
        rd = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
    endtask
    task automatic run_cmd(input logic [7:0] b0, b1, b2, b3, b4);
        logic [7:0] b [5];
        b = '{b0, b1, b2, b3, b4};
        for (int k = 0; k < 5; k++)
            bus_op(1'b1, 10'(4 * k), {24'h0, b[k]});
        bus_op(1'b1, 10'h200, 32'h1);
        // Poll until done and idle; a hang ends in the bench timeout
        do
        begin
            bus_op(1'b0, 10'h204, 32'h0);
        end while (rd[1:0] !== 2'h2);
    endtask
    task automatic chk_set();
        check(32'(o_settings), 32'(exp_set));
        bus_op(1'b0, 10'h208, 32'h0);
        check(rd, {11'h0, exp_set.dac_code, 5'h0, exp_set.ref_level, exp_set.ref_internal, 3'h0,
            exp_set.clk_duty, exp_set.clk_div});
    endtask
    task automatic set_chk(input logic [7:0] b2, b3, b4);
        run_cmd(`GSC_CODE_SET_RUN, 8'hFF, b2, b3, b4);
        if (b2[7])
            {exp_set.clk_duty, exp_set.clk_div} = b2[4:0];
        if (b3[7])
            {exp_set.ref_level, exp_set.ref_internal} = b3[2:0];
        if (b4[7])
            exp_set.dac_code = b4[4:0];
        chk_set();
    endtask
    task automatic clk_meas(input int hi, input int per);
        int n, h, l;
        n = 0;
        h = 0;
        l = 0;
        while (o_clk_out !== 1'b1 && n < 600) begin @(negedge i_clk); n++; end
        while (o_clk_out !== 1'b0 && n < 600) begin @(negedge i_clk); n++; end
        while (o_clk_out === 1'b0 && l < 600) begin @(negedge i_clk); l++; end
        while (o_clk_out === 1'b1 && h < 600) begin @(negedge i_clk); h++; end
        check(h, hi);
        check(h + l, per);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_readback();
        logic [7:0] e;
        for (int s = 0; s < 2; s++)
        begin
            pin_sel <= s[0];
            run_cmd(`GSC_CODE_GET_PINS, 8'h60, 8'h80, 8'h80, 8'h80);
            chk_set();
            for (int k = 0; k < 10; k++)
            begin
                bus_op(1'b0, 10'(256 + 4 * k), 32'h0);
                if (k < 2)
                    e = k ? `GSC_STATUS_OK : `GSC_CODE_GET_PINS;
                else if (k[0])
                    e = pins.gpio_mode[k/2-1] ? {7'h0, pins.dir_in[k/2-1]} : `GSC_DIR_NOT_GPIO;
                else
                    e = pins.gpio_mode[k/2-1] ? {7'h0, pins.level[k/2-1]} : `GSC_LEVEL_NOT_GPIO;
                check(rd, {24'h0, e});
            end
        end
    endtask
    task automatic t_fields();
        set_chk(8'hFD, 8'hFF, 8'hF5);
        set_chk(8'h7F, 8'h06, 8'h1F);
        for (int i = 0; i < 4; i++)
        begin
            set_chk(8'h81 | 8'(i << 3), 8'h80 | 8'(i << 1) | 8'(i & 1), 8'h00);
            if (i == 0)
            begin
                repeat (1100) @(negedge i_clk);
                check(o_clk_out, 32'h0);
            end
            else
                clk_meas(2 * i, 8);
        end
        // Long stable stretch so the free-running clock checks engage
        repeat (1100) @(negedge i_clk);
    endtask
    task automatic t_unknown_reset();
        run_cmd(8'h33, 8'hFF, 8'hFF, 8'hFF, 8'hFF);
        check(rd, {16'h0, 8'h33, 8'h02});
        chk_set();
        bus_op(1'b0, 10'h104, 32'h0);
        check(rd, {24'h0, `GSC_STATUS_BAD_CMD});
        bus_op(1'b0, 10'h3FC, 32'h0);
        check(rd, 32'h0);
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        @(posedge i_clk);
        i_rst_n <= 1'b1;
        // Reset is taken at this edge; look one edge later
        @(posedge i_clk);
        exp_set = {`GSC_DEF_DUTY, `GSC_DEF_DIV, `GSC_DEF_REF_LVL, `GSC_DEF_REF_SRC, `GSC_DEF_DAC};
        chk_set();
        repeat (200) @(posedge i_clk);
    endtask
    // Main sequence
    initial
    begin
        {i_rst_n, i_read, i_write, pin_sel, i_address, i_writedata} = '0;
        {err_count, compares, cyc} = '0;
        exp_set = {`GSC_DEF_DUTY, `GSC_DEF_DIV, `GSC_DEF_REF_LVL, `GSC_DEF_REF_SRC, `GSC_DEF_DAC};
        repeat (10) @(posedge i_clk);
        i_rst_n <= 1'b1;
        chk_set();
        t_readback();
        t_fields();
        t_unknown_reset();
        close_out();
    end
endmodule

// File: verif/gsc_pin_model.sv
// Pin model standing for the four general pins at the far side
`timescale 1ns/1ns
module gsc_pin_model (
    input  wire logic         i_sel,
    output gsc_pkg::gsc_pins_s o_pins
);
    import gsc_pkg::*;
    // Two patterns: all pins general use, or a mix of general and other use
    assign o_pins = i_sel ? {4'h6, 4'hB, 4'hC} : {4'hF, 4'h5, 4'h3};
endmodule
